// File: design/mop_accum.sv
// mop_accum: one saturating overload accumulator
// assumes tick is a one-cycle pulse once per sample period
`timescale 1ns/10ps
module mop_accum import mop_pkg::*; (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        en,
   input  wire logic        tick,
   input  wire logic [15:0] cur,
   input  wire logic [15:0] set,
   input  wire logic [15:0] k,
   output logic      [31:0] acc_q,
   output logic             warn,
   output logic             full
);
   logic [31:0] lim;
   logic [32:0] up;
   logic [31:0] dn;
   assign lim = 32'(set) * 32'(k);
   assign up  = 33'(acc_q) + 33'(cur - set);
   assign dn  = 32'(set - cur);
   // excess over the setting heats, shortfall cools
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= 32'h0000_0000;
      end else if (!en) begin
         acc_q <= 32'h0000_0000;
      end else if (tick) begin
         if (cur >= set) begin
            acc_q <= up[32] ? 32'hFFFF_FFFF : up[31:0];
         end else begin
            acc_q <= (acc_q > dn) ? acc_q - dn : 32'h0000_0000;
         end
      end
   end
   assign warn = en && pct_reached(acc_q, lim, WARN_PCT);
   assign full = en && pct_reached(acc_q, lim, FULL_PCT);
endmodule : mop_accum

// File: design/mop_pkg.sv
// mop_pkg: constants, codes and helpers of the motor overload protection block
// assumes a 100 MHz system clock; currents in 0.01 A, frequency in 0.01 Hz,
// resistance in 0.01 kohm
package mop_pkg;
   // ****************
   // timing
   // ****************
   localparam int          CLK_MHZ     = 100;
   localparam int          SAMPLE_US   = 1000;
   localparam int          SAMPLE_CYC  = SAMPLE_US * CLK_MHZ;
   // ****************
   // register offsets
   // ****************
   localparam logic [7:0]  A_PRIM      = 8'h00;
   localparam logic [7:0]  A_SEC       = 8'h04;
   localparam logic [7:0]  A_RESLVL    = 8'h08;
   localparam logic [7:0]  A_SAM       = 8'h0C;
   localparam logic [7:0]  A_AMS       = 8'h10;
   localparam logic [7:0]  A_CARRIER   = 8'h14;
   localparam logic [7:0]  A_RATED     = 8'h18;
   localparam logic [7:0]  A_OSEL      = 8'h1C;
   localparam logic [7:0]  A_ITSEL     = 8'h20;
   localparam logic [7:0]  A_STATUS    = 8'h40;
   localparam logic [7:0]  A_ACC1      = 8'h44;
   localparam logic [7:0]  A_ACC2      = 8'h48;
   localparam logic [7:0]  A_ACCT      = 8'h4C;
   localparam logic [7:0]  A_RES       = 8'h50;
   localparam int          N_IN        = 5;
   // ****************
   // setting codes and reset values
   // ****************
   localparam logic [15:0] SET_OFF     = 16'hFFFF;
   localparam logic [15:0] SAM_OFF     = 16'h270F;
   localparam logic [15:0] CUR_MAX     = 16'hC350;
   localparam logic [15:0] RES_MIN     = 16'h0032;
   localparam logic [15:0] RES_MAX     = 16'h0BB8;
   localparam logic [15:0] RATED_RST   = 16'h01F4;
   localparam logic [7:0]  AMS_RST     = 8'h00;
   localparam logic [3:0]  CARRIER_RST = 4'h1;
   localparam logic [7:0]  FN_RT       = 8'h03;
   localparam logic [7:0]  FN_OH       = 8'h07;
   localparam logic [7:0]  FN_THP      = 8'h08;
   localparam logic [7:0]  FN_THP_N    = 8'h6C;
   localparam logic [15:0] CT_KNEE     = 16'h0258;
   localparam logic [15:0] STD_KNEE    = 16'h0BB8;
   localparam logic [15:0] MOTOR_K     = 16'h0400;
   localparam logic [15:0] TR_K_BASE   = 16'h0800;
   localparam logic [15:0] TR_K_STEP   = 16'h0040;
   localparam logic [6:0]  WARN_PCT    = 7'h55;
   localparam logic [6:0]  FULL_PCT    = 7'h64;
   localparam logic [7:0]  DIS_RATIO   = 8'h14;
   typedef enum logic [7:0] {
      FLT_NONE  = 8'h00,
      FLT_MOTOR = 8'h01,
      FLT_TRANS = 8'h02,
      FLT_EXT   = 8'h03,
      FLT_RES   = 8'h04
   } mop_fault_t;
   typedef enum logic {MOP_RUN = 1'b0, MOP_TRIP = 1'b1} mop_state_t;
   // acc reached pct percent of lim
   function automatic logic pct_reached(input logic [31:0] acc, input logic [31:0] lim,
                                        input logic [6:0] pct);
      pct_reached = (39'(acc) * 39'(FULL_PCT)) >= (39'(lim) * 39'(pct));
   endfunction : pct_reached
   // zero, or 5 % of rated or less
   function automatic logic too_small(input logic [15:0] set, input logic [15:0] rated);
      too_small = (24'(set) * 24'(DIS_RATIO)) <= 24'(rated);
   endfunction : too_small
endpackage : mop_pkg

// File: design/mop_sync.sv
// mop_sync: two-flop synchroniser for pin inputs
// assumes asynchronous inputs and one system clock
`timescale 1ns/10ps
module mop_sync #(parameter int W = 1) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         q    <= '0;
      end else begin
         s1_q <= d;
         q    <= s1_q;
      end
   end
endmodule : mop_sync

// File: design/mop_top.sv
// mop_top: motor overload protection with two motor accumulators,
// output transistor accumulator, external relay and thermistor trips
// assumes current, frequency and resistance come from logic on CLK_SYS
//
// Overview of operation
// - zero primary setting disables first accumulator
// - transistor protection stays active except while the reset input is pending
// - setting at 5% rated or less disables
// - trip clears only on reset
// - second-set select uses secondary setting, or primary when secondary is off
// - input function code 3 is second-set select
// - active motor integrates actual current
// - inactive enabled motor integrates zero current
// - accumulator held off when setting invalid
// - second accumulator enable conditions
// - 85 percent raises warning and prealarm
// - 100 percent trips with overload fault
// - warning alone never trips
// - warning on output code 8 or 108
// - external relay trips with overheat fault
// - input function code 7 is relay
// - thermistor level reached trips
// - thermistor enabled frees analog input
// - resistance readable only when thermistor enabled
// - higher carrier shortens transistor protection
// - constant-torque motor keeps full low-speed torque
// - constant-torque curve only from 6 Hz
// - thermistor level 0.5 to 30 kohm
`timescale 1ns/10ps
module mop_top import mop_pkg::*; #(
   parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
   input  wire logic        CLK_SYS,
   input  wire logic        RST_N,
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [31:0] REG_RDATA,
   input  wire logic [4:0]  IN_TERM,
   input  wire logic        RESET_IN,
   input  wire logic [15:0] OUT_CURRENT,
   input  wire logic [15:0] OUT_FREQ,
   input  wire logic [15:0] RES_MEAS,
   output logic      [1:0]  OUT_TERM,
   output logic             PREALARM_DISPLAY,
   output logic             TRIP,
   output logic      [7:0]  FAULT_CODE,
   output logic             ANALOG2_FREQ_EN
);
   // ****************
   // declarations
   // ****************
   logic [15:0] prim_q;
   logic [15:0] sec_q;
   logic [15:0] reslvl_q;
   logic [15:0] sam_q;
   logic [7:0]  ams_q;
   logic [3:0]  carrier_q;
   logic [15:0] rated_q;
   logic [7:0]  osel_a_q;
   logic [7:0]  osel_b_q;
   logic [7:0]  itsel_q [N_IN];
   logic [31:0] rdata_q;
   logic [4:0]  in_s;
   logic        rst_in_s;
   logic        rt;
   logic        oh;
   logic        en1;
   logic        en2;
   logic        sel2;
   logic [15:0] sec_set;
   logic [15:0] set1;
   logic [15:0] set2;
   logic [15:0] cur1;
   logic [15:0] cur2;
   logic [15:0] k_t;
   logic [31:0] acc1;
   logic [31:0] acc2;
   logic [31:0] acct;
   logic        warn1;
   logic        warn2;
   logic        full1;
   logic        full2;
   logic        full_t;
   logic        warn;
   logic        ptc_en;
   logic        ptc_trip;
   logic        itsel_hit;
   logic [2:0]  itsel_idx;
   mop_fault_t  cause;
   mop_fault_t  fault_q;
   mop_state_t  st_q;
   logic [31:0] cnt_q;
   logic        tick_q;
   logic [1:0]  out_q;
   logic        pre_q;
   logic        an2_q;

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   // ****************
   // helpers
   // ****************
   function automatic logic is_ct(input logic [7:0] code);
      is_ct = (code == 8'h01) || (code == 8'h0D) || (code == 8'h32) || (code == 8'h35);
   endfunction : is_ct
   // low speed reduces cooling, so the usable setting drops below the knee
   // frequency is an argument so that the continuous assigns follow it
   function automatic logic [15:0] derate(input logic [15:0] set, input logic ct, input logic [15:0] freq);
      logic [15:0] knee;
      knee   = ct ? CT_KNEE : STD_KNEE;
      derate = (freq < knee) ? set - (set >> 2) : set;
   endfunction : derate
   function automatic logic term_drive(input logic [7:0] fsel, input logic w);
      term_drive = (fsel == FN_THP) ? w : (fsel == FN_THP_N) ? !w : 1'b0;
   endfunction : term_drive

   // ****************
   // pin synchronisers
   // ****************
   mop_sync #(.W(5)) u_sync_in (
      .clk   (CLK_SYS),
      .rst_n (RST_N),
      .d     (IN_TERM),
      .q     (in_s)
   );
   mop_sync #(.W(1)) u_sync_rst (
      .clk   (CLK_SYS),
      .rst_n (RST_N),
      .d     (RESET_IN),
      .q     (rst_in_s)
   );

   // ****************
   // register writes
   // ****************
   assign itsel_hit = (REG_ADDR >= A_ITSEL) && (REG_ADDR < A_ITSEL + 8'h14)
                      && (REG_ADDR[1:0] == 2'h0);
   assign itsel_idx = 3'((REG_ADDR - A_ITSEL) >> 2);

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         prim_q    <= RATED_RST;
         sec_q     <= SET_OFF;
         reslvl_q  <= SET_OFF;
         sam_q     <= SAM_OFF;
         ams_q     <= AMS_RST;
         carrier_q <= CARRIER_RST;
         rated_q   <= RATED_RST;
         osel_a_q  <= 8'h00;
         osel_b_q  <= 8'h00;
      end else if (REG_WR) begin
         case (REG_ADDR)
            A_PRIM: begin
               if (REG_WDATA[15:0] <= CUR_MAX) prim_q <= REG_WDATA[15:0];
            end
            A_SEC: begin
               if (REG_WDATA[15:0] <= CUR_MAX || REG_WDATA[15:0] == SET_OFF) sec_q <= REG_WDATA[15:0];
            end
            A_RESLVL: begin
               if ((REG_WDATA[15:0] >= RES_MIN && REG_WDATA[15:0] <= RES_MAX)
                   || REG_WDATA[15:0] == SET_OFF) reslvl_q <= REG_WDATA[15:0];
            end
            A_SAM:     sam_q     <= REG_WDATA[15:0];
            A_AMS:     ams_q     <= REG_WDATA[7:0];
            A_CARRIER: carrier_q <= REG_WDATA[3:0];
            A_RATED:   rated_q   <= REG_WDATA[15:0];
            A_OSEL: begin
               osel_a_q <= REG_WDATA[7:0];
               osel_b_q <= REG_WDATA[15:8];
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         for (int i = 0; i < N_IN; i++) itsel_q[i] <= 8'h00;
      end else if (REG_WR && itsel_hit) begin
         itsel_q[itsel_idx] <= REG_WDATA[7:0];
      end
   end

   // ****************
   // register reads
   // ****************
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         rdata_q <= 32'h0000_0000;
      end else if (!REG_RD) begin
         rdata_q <= 32'h0000_0000;
      end else if (itsel_hit) begin
         rdata_q <= {24'h000000, itsel_q[itsel_idx]};
      end else begin
         case (REG_ADDR)
            A_PRIM:    rdata_q <= {16'h0000, prim_q};
            A_SEC:     rdata_q <= {16'h0000, sec_q};
            A_RESLVL:  rdata_q <= {16'h0000, reslvl_q};
            A_SAM:     rdata_q <= {16'h0000, sam_q};
            A_AMS:     rdata_q <= {24'h000000, ams_q};
            A_CARRIER: rdata_q <= {28'h0000000, carrier_q};
            A_RATED:   rdata_q <= {16'h0000, rated_q};
            A_OSEL:    rdata_q <= {16'h0000, osel_b_q, osel_a_q};
            A_STATUS:  rdata_q <= {16'h0000, fault_q, 1'b0, ptc_en, en2, en1, oh, rt, warn, st_q};
            A_ACC1:    rdata_q <= acc1;
            A_ACC2:    rdata_q <= acc2;
            A_ACCT:    rdata_q <= acct;
            A_RES:     rdata_q <= ptc_en ? {16'h0000, RES_MEAS} : 32'h0000_0000;
            default:   rdata_q <= 32'h0000_0000;
         endcase
      end
   end
   assign REG_RDATA = rdata_q;

   // ****************
   // terminal functions
   // ****************
   always_comb begin
      rt = 1'b0;
      oh = 1'b0;
      for (int i = 0; i < N_IN; i++) begin
         if (itsel_q[i] == FN_RT && in_s[i]) rt = 1'b1;
         if (itsel_q[i] == FN_OH && in_s[i]) oh = 1'b1;
      end
   end

   // ****************
   // accumulator selection
   // ****************
   // a pending reset input also clears the accumulators
   assign en1     = !too_small(prim_q, rated_q) && !rst_in_s;
   assign sec_set = (sec_q == SET_OFF) ? prim_q : sec_q;
   assign en2     = ((sec_q == SET_OFF) ? (sam_q != SAM_OFF) : 1'b1)
                    && !too_small(sec_set, rated_q) && !rst_in_s;
   // select follows the pin whenever a second set is configured, even a disabled one
   assign sel2    = rt && ((sec_q != SET_OFF) || (sam_q != SAM_OFF));
   assign set1    = derate(prim_q, is_ct(ams_q), OUT_FREQ);
   assign set2    = derate(sec_set, (sam_q != SAM_OFF) ? is_ct(sam_q[7:0]) : is_ct(ams_q), OUT_FREQ);
   assign cur1    = sel2 ? 16'h0000 : OUT_CURRENT;
   assign cur2    = sel2 ? OUT_CURRENT : 16'h0000;
   assign k_t     = TR_K_BASE - 16'(carrier_q) * TR_K_STEP;

   // ****************
   // sample tick
   // ****************
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         cnt_q  <= 32'h0000_0000;
         tick_q <= 1'b0;
      end else if (cnt_q == 32'(SAMPLE_CYCLES - 1)) begin
         cnt_q  <= 32'h0000_0000;
         tick_q <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + 32'h0000_0001;
         tick_q <= 1'b0;
      end
   end

   mop_accum u_acc1 (
      .clk   (CLK_SYS),
      .rst_n (RST_N),
      .en    (en1),
      .tick  (tick_q),
      .cur   (cur1),
      .set   (set1),
      .k     (MOTOR_K),
      .acc_q (acc1),
      .warn  (warn1),
      .full  (full1)
   );
   mop_accum u_acc2 (
      .clk   (CLK_SYS),
      .rst_n (RST_N),
      .en    (en2),
      .tick  (tick_q),
      .cur   (cur2),
      .set   (set2),
      .k     (MOTOR_K),
      .acc_q (acc2),
      .warn  (warn2),
      .full  (full2)
   );
   // transistor guard ignores the motor settings entirely
   mop_accum u_acct (
      .clk   (CLK_SYS),
      .rst_n (RST_N),
      .en    (!rst_in_s),
      .tick  (tick_q),
      .cur   (OUT_CURRENT),
      .set   (rated_q),
      .k     (k_t),
      .acc_q (acct),
      .warn  (),
      .full  (full_t)
   );

   // ****************
   // trip and fault
   // ****************
   assign warn     = sel2 ? warn2 : warn1;
   assign ptc_en   = reslvl_q != SET_OFF;
   assign ptc_trip = ptc_en && (RES_MEAS >= reslvl_q);

   // warn is deliberately absent from the causes
   always_comb begin
      cause = FLT_NONE;
      if (full1 || full2) begin
         cause = FLT_MOTOR;
      end else if (full_t) begin
         cause = FLT_TRANS;
      end else if (oh) begin
         cause = FLT_EXT;
      end else if (ptc_trip) begin
         cause = FLT_RES;
      end
   end

   // first fault is kept until a reset; later causes are not recorded
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         st_q    <= MOP_RUN;
         fault_q <= FLT_NONE;
      end else begin
         case (st_q)
            MOP_RUN: begin
               if (cause != FLT_NONE) begin
                  st_q    <= MOP_TRIP;
                  fault_q <= cause;
               end
            end
            MOP_TRIP: begin
               if (rst_in_s) begin
                  st_q    <= MOP_RUN;
                  fault_q <= FLT_NONE;
               end
            end
            default: begin
               st_q    <= MOP_RUN;
               fault_q <= FLT_NONE;
            end
         endcase
      end
   end

   // ****************
   // outputs
   // ****************
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         out_q <= 2'h0;
         pre_q <= 1'b0;
         an2_q <= 1'b1;
      end else begin
         out_q <= {term_drive(osel_b_q, warn), term_drive(osel_a_q, warn)};
         pre_q <= warn;
         an2_q <= !ptc_en;
      end
   end
   assign OUT_TERM         = out_q;
   assign PREALARM_DISPLAY = pre_q;
   assign TRIP             = st_q;
   assign FAULT_CODE       = fault_q;
   assign ANALOG2_FREQ_EN  = an2_q;

   // ****************
   // checks
   // ****************
   sequence s_res_read;
      REG_RD && (REG_ADDR == A_RES) && !ptc_en;
   endsequence
   sequence s_res_zero;
      ##1 (REG_RDATA == 32'h0000_0000);
   endsequence

   chk_acc1_off: assert property (!en1 |=> acc1 == 32'h0000_0000)
      else $error("first accumulator not cleared while disabled");
   chk_small_disable: assert property (too_small(prim_q, rated_q) |-> !en1)
      else $error("small primary setting left accumulator enabled");
   chk_trip_hold: assert property (st_q == MOP_TRIP && !rst_in_s |=> st_q == MOP_TRIP && $stable(fault_q))
      else $error("trip cleared without reset");
   chk_sec_select: assert property (rt && en2 |-> cur1 == 16'h0000 && cur2 == OUT_CURRENT)
      else $error("second set not selected");
   chk_cool_first: assert property (en1 && sel2 && tick_q |=> acc1 <= $past(acc1))
      else $error("inactive motor accumulator heated");
   chk_ext_trip: assert property (oh && st_q == MOP_RUN && !full1 && !full2 && !full_t
                                  |=> st_q == MOP_TRIP && fault_q == FLT_EXT)
      else $error("external relay did not trip");
   chk_ptc_trip: assert property (ptc_trip && st_q == MOP_RUN |=> st_q == MOP_TRIP)
      else $error("thermistor level did not trip");
   chk_warn_pin: assert property (osel_a_q == FN_THP_N && $stable(osel_a_q) |=> OUT_TERM[0] == !$past(warn))
      else $error("inverted warning terminal wrong");
   chk_warn_notrip: assert property (warn && cause == FLT_NONE && st_q == MOP_RUN |=> st_q == MOP_RUN)
      else $error("warning caused a trip");
   chk_analog2: assert property (ptc_en [*2] |-> !ANALOG2_FREQ_EN)
      else $error("analog input still used for frequency");
   chk_res_hidden: assert property (s_res_read |-> s_res_zero)
      else $error("resistance visible while thermistor disabled");
endmodule : mop_top

// File: verification/mop_partner.sv
// mop_partner: current sensor, thermal relay and thermistor model
// assumes the bench sets the wanted levels; all change after an edge
`timescale 1ns/10ps
module mop_partner (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [15:0] cur_cmd,
   input  wire logic [15:0] res_cmd,
   input  wire logic [15:0] freq_cmd,
   input  wire logic        hot,
   output logic      [15:0] cur,
   output logic      [15:0] freq,
   output logic      [15:0] res,
   output logic             relay
);
   // ****************
   // sensor words
   // ****************
   // resets to 60 Hz, above both derating knees, so limits stay exact until the bench moves it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur   <= 16'h0000;
         freq  <= 16'h1770;
         res   <= 16'h0000;
         relay <= 1'b0;
      end else begin
         cur   <= cur_cmd;
         freq  <= freq_cmd;
         res   <= res_cmd;
         relay <= hot;
      end
   end
endmodule : mop_partner

// File: verification/motor_overload_protection_tb.sv
// motor_overload_protection_tb: self-checking bench for mop_top
// assumes mop_pkg and mop_partner compiled first; short sample period
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module motor_overload_protection_tb import mop_pkg::*;;
   logic        clk, rst_n, reg_wr, reg_rd, reset_in, hot;
   logic        prealarm, trip, a2_en, relay;
   logic [1:0]  out_term;
   logic [3:0]  term;
   logic [7:0]  reg_addr, fault_code;
   logic [15:0] cur_cmd, res_cmd, cur, freq, res, cur_v, freq_cmd;
   logic [31:0] reg_wdata, reg_rdata, rd_v, a1_v, lfsr_v;
   int          mismatches, cmp_count, diff_v, lim_v;
   always #5 clk = ~clk;
   mop_top #(.SAMPLE_CYCLES(4)) u_dut (
      .CLK_SYS(clk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .IN_TERM({term, relay}),
      .RESET_IN(reset_in), .OUT_CURRENT(cur), .OUT_FREQ(freq), .RES_MEAS(res),
      .OUT_TERM(out_term), .PREALARM_DISPLAY(prealarm), .TRIP(trip),
      .FAULT_CODE(fault_code), .ANALOG2_FREQ_EN(a2_en));
   mop_partner u_partner (
      .clk(clk), .rst_n(rst_n), .cur_cmd(cur_cmd), .res_cmd(res_cmd), .freq_cmd(freq_cmd), .hot(hot),
      .cur(cur), .freq(freq), .res(res), .relay(relay));
   // ****************
   // bus and helpers
   // ****************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd
   // reset pin held well past its two-flop sync
   task automatic clr();
      @(posedge clk);
      reset_in <= 1'b1;
      repeat (4) @(posedge clk);
      reset_in <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask : clr
   task automatic wait_hi(input bit sel, input int lim);
      int n;
      n = 0;
      while (((sel ? prealarm : trip) !== 1'b1) && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= lim) begin
         mismatches++;
         $display("wait ran out at %0t", $time);
      end
   endtask : wait_hi
   task automatic en2_chk(input logic [31:0] sec, input logic [31:0] sam, input logic e);
      wr(A_SEC, sec);
      wr(A_SAM, sam);
      rd(A_STATUS, rd_v);
      `CHK(rd_v[5], e)
   endtask : en2_chk
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out
   // ****************
   // tests
   // ****************
   initial begin
      clk = 0; rst_n = 0; reg_wr = 0; reg_rd = 0; reset_in = 0; hot = 0; term = 0;
      reg_addr = 0; reg_wdata = 0; cur_cmd = 0; res_cmd = 0; lfsr_v = 32'hD2B9EC90;
      freq_cmd = 16'h1770;
      mismatches = 0; cmp_count = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd(A_STATUS, rd_v);
      `CHK(rd_v, 32'h00000010)
      rd(A_ACC1, rd_v);
      `CHK(rd_v, 32'h0)
      rd(8'h3C, rd_v);
      `CHK(rd_v, 32'h0)
      // relay ignored until a terminal carries its function
      @(posedge clk);
      hot <= 1'b1;
      repeat (10) @(posedge clk);
      `CHK(trip, 1'b0)
      wr(A_ITSEL, 32'h7);
      wait_hi(0, 20);
      `CHK(fault_code, 8'h03)
      @(posedge clk);
      hot <= 1'b0;
      repeat (8) @(posedge clk);
      `CHK(trip, 1'b1)
      clr();
      `CHK(trip, 1'b0)
      $display("test relay done");
      res_cmd <= 16'h0100;
      wr(A_RESLVL, 32'h20);
      rd(A_RESLVL, rd_v);
      `CHK(rd_v, 32'h0000FFFF)
      rd(A_RES, rd_v);
      `CHK(rd_v, 32'h0)
      wr(A_RESLVL, 32'h0200);
      rd(A_RES, rd_v);
      `CHK(rd_v, 32'h00000100)
      `CHK(a2_en, 1'b0)
      `CHK(trip, 1'b0)
      res_cmd <= 16'h0200;
      wait_hi(0, 10);
      `CHK(fault_code, 8'h04)
      res_cmd <= 16'h0000;
      wr(A_RESLVL, 32'hFFFF);
      clr();
      `CHK(a2_en, 1'b1)
      $display("test thermistor done");
      wr(A_PRIM, 32'h1A);
      rd(A_STATUS, rd_v);
      `CHK(rd_v[4], 1'b1)
      wr(A_PRIM, 32'h19);
      rd(A_STATUS, rd_v);
      `CHK(rd_v[4], 1'b0)
      wr(A_PRIM, 32'h0);
      rd(A_STATUS, rd_v);
      `CHK(rd_v[4], 1'b0)
      cur_cmd <= 16'hC350;
      wait_hi(0, 400);
      `CHK(fault_code, 8'h02)
      rd(A_ACC1, rd_v);
      `CHK(rd_v, 32'h0)
      cur_cmd <= 16'h0000;
      clr();
      $display("test transistor done");
      // random current kept small enough that warn and trip land on separate ticks
      wr(A_OSEL, 32'h6C08);
      wr(A_PRIM, 32'h0100);
      #1;
      `CHK(out_term, 2'b10)
      lfsr_v = lfsr(lfsr_v);
      cur_v = {4'h8, lfsr_v[11:0]};
      diff_v = int'(cur_v) - 256;
      lim_v = 256 * 1024;
      cur_cmd <= cur_v;
      wait_hi(1, 300);
      `CHK(prealarm, 1'b1)
      `CHK(trip, 1'b0)
      `CHK(out_term, 2'b01)
      rd(A_ACC1, rd_v);
      `CHK(rd_v % 32'(diff_v), 32'h0)
      `CHK(64'(rd_v) * 64'd100 >= 64'(lim_v) * 64'd85, 1'b1)
      wait_hi(0, 300);
      `CHK(fault_code, 8'h01)
      cur_cmd <= 16'h0000;
      clr();
      rd(A_ACC1, rd_v);
      `CHK(rd_v, 32'h0)
      $display("test overload done");
      // current equal to the setting: only a derated setting heats
      wr(A_AMS, 32'h1);
      cur_cmd  <= 16'h0100;
      freq_cmd <= 16'h0BB7;
      repeat (40) @(posedge clk);
      rd(A_ACC1, rd_v);
      `CHK(rd_v, 32'h0)
      freq_cmd <= 16'h0257;
      repeat (40) @(posedge clk);
      rd(A_ACC1, rd_v);
      `CHK(rd_v != 0 && rd_v % 32'd64 == 0, 1'b1)
      cur_cmd  <= 16'h0000;
      freq_cmd <= 16'h1770;
      wr(A_AMS, 32'h0);
      clr();
      $display("test derating done");
      wr(A_ITSEL + 8'h04, 32'h3);
      wr(A_SEC, 32'h0100);
      cur_cmd <= 16'h0180;
      repeat (80) @(posedge clk);
      rd(A_ACC1, a1_v);
      `CHK(a1_v != 0, 1'b1)
      term <= 4'h1;
      repeat (200) @(posedge clk);
      rd(A_STATUS, rd_v);
      `CHK(rd_v[5:2], 4'b1101)
      rd(A_ACC1, rd_v);
      `CHK(rd_v, 32'h0)
      rd(A_ACC2, rd_v);
      `CHK(rd_v != 0 && rd_v % 32'd128 == 0, 1'b1)
      en2_chk(32'hFFFF, 32'h270F, 1'b0);
      en2_chk(32'hFFFF, 32'h0, 1'b1);
      en2_chk(32'h0, 32'h0, 1'b0);
      $display("test second set done");
      close_out();
   end
   initial begin
      #100000;
      mismatches++;
      $display("watchdog expired");
      close_out();
   end
endmodule : motor_overload_protection_tb
